// ### cmd_decoder.v
// What this block does
// [RQ1] every register access opens with a command byte from the host
// [RQ2] the command byte picks the target register and direction of next phase
// [RQ3] command bit 7 must be zero or the byte is refused
// [RQ4] command bit 6: zero is a host write, one a device read
// [RQ5] bits 5:0 decode status, modes, checksum, data, io config, identity
// [RQ6] channels from 010000, offsets from 110000, gains from 111000 by index
// [RQ7] eight setup registers at 100000 to 100111 by setup number
// [RQ8] filter registers start at 101000 in index order
// [RQ9] data phase lasts register width in bytes, then back to command
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_consts.vh"

module cmd_decoder #(
  parameter DATA_W = 24
) (
  input  wire              MCLK_IN,
  input  wire              RESET_N_IN,
  input  wire              CEN_IN,
  input  wire              SCLK_IN,
  input  wire              CS_N_IN,
  input  wire              DIN_IN,
  output reg               DOUT_OUT,
  output wire              DOUT_OE_OUT,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [11:0]       PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output wire              PREADY,
  output reg               PSLVERR,
  output reg  [5:0]        TARGET_SELECT_OUT,
  output reg  [3:0]        TARGET_CLASS_OUT,
  output reg  [3:0]        TARGET_INDEX_OUT,
  output reg               READ_NOT_WRITE_OUT,
  output reg               CMD_VALID_OUT,
  input  wire [DATA_W-1:0] RD_DATA_IN,
  output reg  [DATA_W-1:0] WR_DATA_OUT,
  output reg               WR_VALID_OUT,
  output reg               RD_DONE_OUT
);

  // -------------------------------------------------------------
  // decode functions
  // -------------------------------------------------------------
  function [3:0] class_of;
    input [5:0] a;
    begin
      if (a == `TA_STATUS) class_of = `CLS_STATUS;                  // see [RQ5]
      else if (a == `TA_ADC_MODE) class_of = `CLS_ADC_MODE;
      else if (a == `TA_IF_MODE) class_of = `CLS_IF_MODE;
      else if (a == `TA_CHECKSUM) class_of = `CLS_CHECKSUM;
      else if (a == `TA_DATA) class_of = `CLS_DATA;
      else if (a == `TA_IO_CFG) class_of = `CLS_IO_CFG;
      else if (a == `TA_IDENT) class_of = `CLS_IDENT;
      else if ({a[5:4], 4'h0} == `TA_CHAN_BASE)
        class_of = `CLS_CHAN;                                       // see [RQ6]
      else if ({a[5:3], 3'h0} == `TA_SETUP_BASE)
        class_of = `CLS_SETUP;                                      // see [RQ7]
      else if ({a[5:3], 3'h0} == `TA_FILT_BASE)
        class_of = `CLS_FILT;                                       // see [RQ8]
      else if ({a[5:3], 3'h0} == `TA_OFFS_BASE)
        class_of = `CLS_OFFS;                                       // see [RQ6]
      else if ({a[5:3], 3'h0} == `TA_GAIN_BASE)
        class_of = `CLS_GAIN;                                       // see [RQ6]
      else class_of = `CLS_NONE;
    end
  endfunction

  function [3:0] index_of;
    input [5:0] a;
    begin
      if ({a[5:4], 4'h0} == `TA_CHAN_BASE) index_of = a[3:0];       // see [RQ6]
      else if (a[5]) index_of = {1'b0, a[2:0]};                     // see [RQ7]
      else index_of = 4'h0;
    end
  endfunction

  function [1:0] bytes_of;
    input [3:0] c;
    begin
      case (c)
        `CLS_STATUS:   bytes_of = `LEN_ONE;                         // see [RQ9]
        `CLS_CHECKSUM,
        `CLS_DATA,
        `CLS_OFFS,
        `CLS_GAIN:     bytes_of = `LEN_THREE;
        `CLS_NONE:     bytes_of = `LEN_NONE;
        default:       bytes_of = `LEN_TWO;
      endcase
    end
  endfunction

  // -------------------------------------------------------------
  // link front end
  // -------------------------------------------------------------
  wire rise;
  wire fall;
  wire cs_n_s;
  wire din_s;

  serial_front u_front (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESET_N_IN),
    .cen_in   (CEN_IN),
    .sclk_in  (SCLK_IN),
    .cs_n_in  (CS_N_IN),
    .din_in   (DIN_IN),
    .rise_out (rise),
    .fall_out (fall),
    .cs_n_out (cs_n_s),
    .din_out  (din_s)
  );

  // -------------------------------------------------------------
  // command state machine
  // -------------------------------------------------------------
  localparam ST_CMD  = 1'b0;
  localparam ST_DATA = 1'b1;

  reg              state_q;
  reg [4:0]        cnt_q;
  reg [7:0]        cmd_sh_q;
  reg [7:0]        command_word_q;
  reg [4:0]        last_bit_q;
  reg [DATA_W-1:0] sh_q;
  reg              en_q;
  reg              bad_start_q;
  reg              bad_addr_q;
  reg [15:0]       count_q;
  reg              clr_req;
  wire [7:0]       cmd_full = {cmd_sh_q[6:0], din_s};
  wire [3:0]       cls_full = class_of(cmd_full[`CMD_ADDR_MSB:0]);
  wire [1:0]       len_full = bytes_of(cls_full);
  wire             active   = en_q & ~cs_n_s;
  wire             cmd_done = state_q == ST_CMD && rise
                              && cnt_q == `CMD_BITS_LAST;
  wire             start_ok = ~cmd_full[`CMD_START_BIT];
  wire             accept   = active & cmd_done & start_ok
                              & (len_full != `LEN_NONE);

  assign DOUT_OE_OUT = active & (state_q == ST_DATA) & READ_NOT_WRITE_OUT;

  always @(posedge MCLK_IN) begin
    if (!RESET_N_IN) begin
      state_q            <= ST_CMD;
      cnt_q              <= 5'h00;
      cmd_sh_q           <= `CMD_RESET;
      command_word_q     <= `CMD_RESET;
      last_bit_q         <= 5'h00;
      sh_q               <= {DATA_W{1'b0}};
      DOUT_OUT           <= 1'b0;
      TARGET_SELECT_OUT  <= 6'h00;
      TARGET_CLASS_OUT   <= `CLS_STATUS;
      TARGET_INDEX_OUT   <= 4'h0;
      READ_NOT_WRITE_OUT <= 1'b0;
      CMD_VALID_OUT      <= 1'b0;
      WR_DATA_OUT        <= {DATA_W{1'b0}};
      WR_VALID_OUT       <= 1'b0;
      RD_DONE_OUT        <= 1'b0;
      bad_start_q        <= 1'b0;
      bad_addr_q         <= 1'b0;
      count_q            <= 16'h0000;
    end else if (CEN_IN) begin
      CMD_VALID_OUT <= 1'b0;
      WR_VALID_OUT  <= 1'b0;
      RD_DONE_OUT   <= 1'b0;
      // sticky flags: a new event wins over a clear
      if (active & cmd_done & ~start_ok)
        bad_start_q <= 1'b1;                                        // see [RQ3]
      else if (clr_req)
        bad_start_q <= 1'b0;
      if (active & cmd_done & start_ok & (len_full == `LEN_NONE))
        bad_addr_q <= 1'b1;
      else if (clr_req)
        bad_addr_q <= 1'b0;
      if (!active) begin
        state_q <= ST_CMD;                                          // see [RQ1]
        cnt_q   <= 5'h00;
      end else begin
        case (state_q)
          ST_CMD: begin
            if (rise) begin
              cmd_sh_q <= cmd_full;
              cnt_q    <= cnt_q + 5'h01;
            end
            if (cmd_done) begin
              cnt_q <= 5'h00;
              if (accept) begin
                state_q            <= ST_DATA;                      // see [RQ2]
                command_word_q     <= cmd_full;
                TARGET_SELECT_OUT  <= cmd_full[`CMD_ADDR_MSB:0];    // see [RQ5]
                TARGET_CLASS_OUT   <= cls_full;
                TARGET_INDEX_OUT   <= index_of(cmd_full[5:0]);
                READ_NOT_WRITE_OUT <= cmd_full[`CMD_DIR_BIT];       // see [RQ4]
                CMD_VALID_OUT      <= 1'b1;
                count_q            <= count_q + 16'h0001;
                last_bit_q         <= {len_full, 3'h0} - 5'h01;     // see [RQ9]
                sh_q <= RD_DATA_IN << {`LEN_THREE - len_full, 3'h0};
                DOUT_OUT <= RD_DATA_IN[{len_full, 3'h0} - 5'h01];
              end
            end
          end
          ST_DATA: begin
            if (rise) begin
              cnt_q <= cnt_q + 5'h01;
              if (!READ_NOT_WRITE_OUT)
                sh_q <= {sh_q[DATA_W-2:0], din_s};                  // see [RQ4]
              if (cnt_q == last_bit_q) begin
                state_q <= ST_CMD;                                  // see [RQ9]
                cnt_q   <= 5'h00;
                if (READ_NOT_WRITE_OUT)
                  RD_DONE_OUT <= 1'b1;
                else begin
                  WR_DATA_OUT  <= {sh_q[DATA_W-2:0], din_s};
                  WR_VALID_OUT <= 1'b1;
                end
              end
            end
            if (fall && READ_NOT_WRITE_OUT) begin
              sh_q     <= {sh_q[DATA_W-2:0], 1'b0};
              DOUT_OUT <= sh_q[DATA_W-1];                           // see [RQ4]
            end
          end
          default: state_q <= ST_CMD;
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // apb slave
  // -------------------------------------------------------------
  wire apb_acc = PSEL & PENABLE & CEN_IN;
  wire hit     = PADDR == `ADDR_CTRL || PADDR == `ADDR_STAT
                 || PADDR == `ADDR_COUNT;

  assign PREADY = 1'b1;

  always @* begin
    clr_req = apb_acc & PWRITE & (PADDR == `ADDR_CTRL)
              & PWDATA[`CTRL_CLR_BIT];
  end

  always @* begin
    PSLVERR = PSEL & PENABLE & ~hit;
    case (PADDR)
      `ADDR_CTRL:  PRDATA = {31'h0000_0000, en_q};
      `ADDR_STAT:  PRDATA = {20'h0_0000, READ_NOT_WRITE_OUT, state_q,
                             bad_addr_q, bad_start_q, command_word_q};
      `ADDR_COUNT: PRDATA = {16'h0000, count_q};
      default:     PRDATA = 32'h0000_0000;
    endcase
  end

  always @(posedge MCLK_IN) begin
    if (!RESET_N_IN)
      en_q <= `CTRL_RESET;
    else if (apb_acc && PWRITE && PADDR == `ADDR_CTRL)
      en_q <= PWDATA[`CTRL_EN_BIT];
  end

endmodule

`default_nettype wire

// ### cmd_decoder_consts.vh
`ifndef CMD_DECODER_CONSTS_VH
`define CMD_DECODER_CONSTS_VH

// ---------------------------------------------------------------
// command byte layout
// ---------------------------------------------------------------
`define CMD_RESET        8'h00
`define CMD_START_BIT    7
`define CMD_DIR_BIT      6
`define CMD_ADDR_MSB     5
`define CMD_BITS_LAST    5'h07

// ---------------------------------------------------------------
// target register addresses
// ---------------------------------------------------------------
`define TA_STATUS        6'h00
`define TA_ADC_MODE      6'h01
`define TA_IF_MODE       6'h02
`define TA_CHECKSUM      6'h03
`define TA_DATA          6'h04
`define TA_IO_CFG        6'h06
`define TA_IDENT         6'h07
`define TA_CHAN_BASE     6'h10
`define TA_SETUP_BASE    6'h20
`define TA_FILT_BASE     6'h28
`define TA_OFFS_BASE     6'h30
`define TA_GAIN_BASE     6'h38

// ---------------------------------------------------------------
// target classes
// ---------------------------------------------------------------
`define CLS_STATUS       4'h0
`define CLS_ADC_MODE     4'h1
`define CLS_IF_MODE      4'h2
`define CLS_CHECKSUM     4'h3
`define CLS_DATA         4'h4
`define CLS_IO_CFG       4'h6
`define CLS_IDENT        4'h7
`define CLS_CHAN         4'h8
`define CLS_SETUP        4'h9
`define CLS_FILT         4'ha
`define CLS_OFFS         4'hb
`define CLS_GAIN         4'hc
`define CLS_NONE         4'hf

// ---------------------------------------------------------------
// data phase lengths in bytes
// ---------------------------------------------------------------
`define LEN_NONE         2'h0
`define LEN_ONE          2'h1
`define LEN_TWO          2'h2
`define LEN_THREE        2'h3

// ---------------------------------------------------------------
// apb register map
// ---------------------------------------------------------------
`define ADDR_CTRL        12'h000
`define ADDR_STAT        12'h004
`define ADDR_COUNT       12'h008
`define CTRL_EN_BIT      0
`define CTRL_CLR_BIT     1
`define CTRL_RESET       1'h1
`define STAT_BAD_START   8
`define STAT_BAD_ADDR    9
`define STAT_BUSY        10
`define STAT_DIR         11

`endif

// ### serial_front.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// pin synchroniser and link clock edge finder
// ---------------------------------------------------------------
module serial_front (
  input  wire clk_in,
  input  wire rst_n_in,
  input  wire cen_in,
  input  wire sclk_in,
  input  wire cs_n_in,
  input  wire din_in,
  output wire rise_out,
  output wire fall_out,
  output wire cs_n_out,
  output wire din_out
);

  reg [2:0] sclk_q;
  reg [1:0] cs_q;
  reg [1:0] din_q;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      sclk_q <= 3'h7;
      cs_q   <= 2'h3;
      din_q  <= 2'h0;
    end else if (cen_in) begin
      sclk_q <= {sclk_q[1:0], sclk_in};
      cs_q   <= {cs_q[0], cs_n_in};
      din_q  <= {din_q[0], din_in};
    end
  end

  // edges judged on second and third stage only
  assign rise_out = cen_in & sclk_q[1] & ~sclk_q[2];
  assign fall_out = cen_in & ~sclk_q[1] & sclk_q[2];
  assign cs_n_out = cs_q[1];
  assign din_out  = din_q[1];

endmodule

`default_nettype wire

// ### cmd_decoder_fix.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### cmd_decoder_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_consts.vh"
// ---------------------------------------------------------------
// decode checks
// ---------------------------------------------------------------
module cmd_decoder_checker #(
  parameter DATA_W = 24
) (
  input wire logic       MCLK_IN,
  input wire logic       RESET_N_IN,
  input wire logic       CEN_IN,
  input wire logic       DOUT_OE_OUT,
  input wire logic [5:0] TARGET_SELECT_OUT,
  input wire logic [3:0] TARGET_CLASS_OUT,
  input wire logic [3:0] TARGET_INDEX_OUT,
  input wire logic       READ_NOT_WRITE_OUT,
  input wire logic       WR_VALID_OUT,
  input wire logic       RD_DONE_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  wire [5:0] a = TARGET_SELECT_OUT;
  wire [3:0] c = TARGET_CLASS_OUT;
  wire [3:0] k = TARGET_INDEX_OUT;
  chk_fixed_map: assert property (
    a[5:3] == 3'h0 && a != 6'h05 |-> c == {1'b0, a[2:0]})
    else $error("fixed class wrong");
  chk_unmapped_map: assert property (
    !(a == 6'h05 || a[5:3] == 3'h1) && c != `CLS_NONE)
    else $error("unmapped code accepted");
  chk_chan_map: assert property (
    a[5:4] == 2'h1 |-> c == `CLS_CHAN && k == a[3:0])
    else $error("channel decode wrong");
  chk_offs_gain: assert property (
    a[5:4] == 2'h3 |-> c == (a[3] ? `CLS_GAIN : `CLS_OFFS)
    && k == {1'b0, a[2:0]}) else $error("offset gain decode wrong");
  chk_setup_filt: assert property (
    a[5:4] == 2'h2 |-> c == (a[3] ? `CLS_FILT : `CLS_SETUP)
    && k == {1'b0, a[2:0]}) else $error("setup filter decode wrong");
  chk_read_drive: assert property (
    DOUT_OE_OUT |-> READ_NOT_WRITE_OUT && c != `CLS_NONE)
    else $error("drive on write");
  chk_write_dir: assert property (
    WR_VALID_OUT |-> !READ_NOT_WRITE_OUT) else $error("write on read");
  chk_done_dir: assert property (
    RD_DONE_OUT |-> READ_NOT_WRITE_OUT && c != `CLS_NONE)
    else $error("read done wrong");
  chk_wr_pulse: assert property (
    WR_VALID_OUT && CEN_IN |=> !WR_VALID_OUT) else $error("long pulse");
endmodule

bind cmd_decoder cmd_decoder_checker #(.DATA_W(DATA_W)) checker_i (
  .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .CEN_IN(CEN_IN),
  .DOUT_OE_OUT(DOUT_OE_OUT), .TARGET_SELECT_OUT(TARGET_SELECT_OUT),
  .TARGET_CLASS_OUT(TARGET_CLASS_OUT), .TARGET_INDEX_OUT(TARGET_INDEX_OUT),
  .READ_NOT_WRITE_OUT(READ_NOT_WRITE_OUT), .WR_VALID_OUT(WR_VALID_OUT),
  .RD_DONE_OUT(RD_DONE_OUT));
`default_nettype wire

// ### link_host.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// serial host model
// ---------------------------------------------------------------
module link_host (
  output var logic sclk_out,
  output var logic cs_n_out,
  output var logic din_out,
  input  wire logic dout_in,
  input  wire logic oe_in
);
  logic [23:0] rd_q = 24'h00_0000;
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  task automatic bit_io(input logic b);
    sclk_out = 1'b0;
    din_out = b;
    #40;
    sclk_out = 1'b1;
    rd_q = {rd_q[22:0], oe_in ? dout_in : ~rd_q[0]};
    #40;
  endtask
  task automatic frame(input logic [7:0] cmd, input int nb,
                       input logic [23:0] wd);
    int i;
    #3;
    cs_n_out = 1'b0;
    #40;
    for (i = 7; i >= 0; i--)
      bit_io(cmd[i]);
    for (i = nb - 1; i >= 0; i--)
      bit_io(wd[i]);
    cs_n_out = 1'b1;
    din_out = ~din_out;
    #200;
  endtask
endmodule
`default_nettype wire

// ### cmd_decoder_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decoder_consts.vh"
module cmd_decoder_bench;
  logic        mclk, rst_n, cen, sclk, cs_n, din, dout, oe, perr_q;
  logic        psel, pen, pwr, pready, perr, rnw, cval, wval, rdone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, apb_rd;
  logic [5:0]  tsel;
  logic [3:0]  tcls, tidx;
  logic [23:0] rd_data, wr_data;
  logic [15:0] cmd_q[$];
  logic [23:0] wr_q[$];
  logic [47:0] rd_q[$];
  int          num_errors, tests_run, seed, i, n_cmd;
  cmd_decoder cmd_decoder_i (
    .MCLK_IN(mclk), .RESET_N_IN(rst_n), .CEN_IN(cen), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .DIN_IN(din), .DOUT_OUT(dout), .DOUT_OE_OUT(oe),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
    .TARGET_SELECT_OUT(tsel), .TARGET_CLASS_OUT(tcls),
    .TARGET_INDEX_OUT(tidx), .READ_NOT_WRITE_OUT(rnw),
    .CMD_VALID_OUT(cval), .RD_DATA_IN(rd_data), .WR_DATA_OUT(wr_data),
    .WR_VALID_OUT(wval), .RD_DONE_OUT(rdone));
  link_host link_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
    .dout_in(dout), .oe_in(oe));
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  function automatic logic [15:0] exp_cmd(input logic r,
                                          input logic [5:0] a);
    logic [3:0] c;
    case (a[5:3])
      3'h2, 3'h3: c = `CLS_CHAN;
      3'h4: c = `CLS_SETUP;
      3'h5: c = `CLS_FILT;
      3'h6: c = `CLS_OFFS;
      3'h7: c = `CLS_GAIN;
      3'h0: c = (a == 6'h05) ? `CLS_NONE : {1'b0, a[2:0]};
      default: c = `CLS_NONE;
    endcase
    return {a[5] | a[4], r, a, c,
            (a[5:4] == 2'h1) ? a[3:0] : {1'b0, a[2:0]}};
  endfunction
  function automatic int nbytes(input logic [3:0] c);
    case (c)
      `CLS_STATUS: return 1;
      `CLS_CHECKSUM, `CLS_DATA, `CLS_OFFS, `CLS_GAIN: return 3;
      `CLS_NONE: return 0;
      default: return 2;
    endcase
  endfunction
  task compare(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task results;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1 && ++n < 16);
    if (n >= 16) begin
      compare("apb ready", 24'h00_0001, 24'h00_0000);
      results();
    end
    apb_rd = prdata;
    perr_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task send(input logic r, input logic [5:0] a, input logic cut);
    logic [15:0] e;
    logic [23:0] v, m;
    int n;
    e = exp_cmd(r, a);
    n = nbytes(e[7:4]);
    v = $random(seed);
    m = ~(24'hff_ffff << (8 * n));
    if (n > 0) begin
      cmd_q.push_back(e);
      n_cmd++;
    end
    if (!cut && n > 0 && r)
      rd_q.push_back({m, v & m});
    if (!cut && n > 0 && !r)
      wr_q.push_back(v & m);
    @(posedge mclk);
    rd_data <= v;
    link_host_i.frame({1'b0, r, a}, cut ? 8 : 8 * n, v);
  endtask
  always @(posedge mclk) begin : watch
    logic [15:0] e;
    logic [15:0] g;
    logic [47:0] d;
    logic [23:0] w;
    if (cval === 1'b1) begin
      e = cmd_q.size() ? cmd_q.pop_front() : 16'hxxxx;
      g = {e[15], rnw, tsel, tcls, e[15] ? tidx : e[3:0]};
      compare("command", e, g);
    end
    if (wval === 1'b1) begin
      w = wr_q.size() ? wr_q.pop_front() : 24'hxx_xxxx;
      compare("write", w, wr_data);
    end
    if (rdone === 1'b1) begin
      d = rd_q.size() ? rd_q.pop_front() : 48'hxxxx_xxxx_xxxx;
      compare("read", d[23:0], link_host_i.rd_q & d[47:24]);
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 52876;
    {rst_n, cen, psel, pen, pwr} = 5'h08;
    {paddr, pwdata, rd_data} = 68'h0_0000_0000_0000_0000;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    compare("ctrl reset", `CTRL_RESET, apb_rd[`CTRL_EN_BIT]);
    cen <= 1'b0;
    apb(1'b1, `ADDR_CTRL, 32'h0000_0000);
    cen <= 1'b1;
    apb(1'b0, `ADDR_CTRL, 32'h0000_0000);
    compare("cen freeze", 1'b1, apb_rd[`CTRL_EN_BIT]);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    compare("unmapped", 1'b1, perr_q);
    for (i = 0; i < 64; i++)
      send(1'($random(seed)), i[5:0], 1'b0);
    link_host_i.frame(8'hc4, 0, 24'h00_0000);
    send(1'b0, `TA_DATA, 1'b1);
    send(1'b1, 6'h3f, 1'b0);
    apb(1'b0, `ADDR_STAT, 32'h0000_0000);
    compare("bad start", 1'b1, apb_rd[`STAT_BAD_START]);
    compare("bad addr", 1'b1, apb_rd[`STAT_BAD_ADDR]);
    compare("cmd word", 8'h7f, apb_rd[7:0]);
    compare("dir busy", 2'h2, apb_rd[`STAT_DIR:`STAT_BUSY]);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, `ADDR_STAT, 32'h0000_0000);
    compare("sticky", 2'h0, apb_rd[9:8]);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0000);
    link_host_i.frame(8'h10, 16, 24'h00_1234);
    apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
    send(1'b0, `TA_SETUP_BASE, 1'b0);
    repeat (20) @(posedge mclk);
    apb(1'b0, `ADDR_COUNT, 32'h0000_0000);
    compare("count", n_cmd, apb_rd[15:0]);
    compare("pending", 24'h00_0000, cmd_q.size() + wr_q.size() + rd_q.size());
    results();
  end
  initial begin
    #500000;
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
